// >>> tb/lpm_fw_model.sv
`timescale 1ns/1ps

// Firmware side: classic single-cycle master plus entry habits
module lpm_fw_model (
  input wire logic clk_i,
  output logic wb_cyc_o,
  output logic wb_stb_o,
  output logic wb_we_o,
  output logic [7:0] wb_adr_o,
  output logic [3:0] wb_sel_o,
  output logic [31:0] wb_dat_o,
  input wire logic [31:0] wb_dat_i,
  input wire logic wb_ack_i
);
  // Idle bus from time zero
  initial begin
    wb_cyc_o = 1'b0;
    wb_stb_o = 1'b0;
    wb_we_o = 1'b0;
    wb_adr_o = 8'h00;
    wb_sel_o = 4'h0;
    wb_dat_o = 32'h0000_0000;
  end

  // Request stays put until ack is seen high at an edge
  task automatic xfer(input logic we, input logic [7:0] adr,
                      input logic [3:0] sel, input logic [31:0] wdat,
                      output logic [31:0] rdat);
    @(posedge clk_i);
    wb_cyc_o <= 1'b1;
    wb_stb_o <= 1'b1;
    wb_we_o <= we;
    wb_adr_o <= adr;
    wb_sel_o <= sel;
    wb_dat_o <= wdat;
    @(posedge clk_i);
    while (wb_ack_i !== 1'b1) @(posedge clk_i);
    rdat = wb_dat_i;
    wb_cyc_o <= 1'b0;
    wb_stb_o <= 1'b0;
    wb_we_o <= 1'b0;
  endtask

  // clock source already moved to a safe oscillator
  // mode and enables in one write
  task automatic enter_lp(input logic [7:0] mode_en);
    logic [31:0] dummy;
    xfer(1'b1, lpm_pkg::OFS_CFG, 4'h1, {24'h00_0000, mode_en}, dummy);
  endtask

  // let a pending pin reset act before re-entry
  task automatic hold_off();
    repeat (lpm_pkg::RST_WAIT_CYC) @(posedge clk_i);
  endtask
endmodule

// >>> tb/testbench.sv
`timescale 1ns/1ps

module testbench;
  typedef struct packed {
    logic [7:0] cfg;
    logic [2:0] src;
    logic wake;
    logic [7:0] flags;
  } lpm_row_t;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic cyc, stb, we, ack;
  logic [7:0] adr;
  logic [3:0] sel;
  logic [31:0] wdat, dat, rdat;
  // Bits 4:0 wake sources, bit 5 reset pin level (idle high)
  logic [5:0] src = 6'h20;
  logic reset_src = 1'b0;
  logic sys_clk_en, osc_en, halt, core_en, ram_vdd, retain, hold;
  logic wake_n, pin_rst, full_por, mon_en, xram_we;
  int error_cnt = 0;
  int checks_done = 0;
  int n;
  lpm_row_t rows [14];

  always #2.5 clk_i = ~clk_i;

  lpm_fw_model fw (.clk_i(clk_i), .wb_cyc_o(cyc), .wb_stb_o(stb),
    .wb_we_o(we), .wb_adr_o(adr), .wb_sel_o(sel), .wb_dat_o(wdat),
    .wb_dat_i(dat), .wb_ack_i(ack));

  lpm_top DUT (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc),
    .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel),
    .wb_dat_i(wdat), .wb_dat_o(dat), .wb_ack_o(ack),
    .csense_done_i(src[0]), .rtc_osc_fail_i(src[1]),
    .rtc_alarm_i(src[2]), .port_match_i(src[3]), .cmp0_i(src[4]),
    .rst_pin_n_i(src[5]), .reset_src_i(reset_src),
    .sys_clk_en_o(sys_clk_en), .osc_en_o(osc_en), .cpu_halt_o(halt),
    .core_reg_en_o(core_en), .ram_on_vdd_o(ram_vdd), .retain_o(retain),
    .pin_hold_o(hold), .wake_req_n_o(wake_n), .pin_reset_o(pin_rst),
    .full_por_o(full_por), .por_mon_en_o(mon_en),
    .xram0_zero_we_o(xram_we));

  ////////////////////////////////////////////////////////////
  task automatic check(input logic [31:0] seen, input logic [31:0] exp,
                       input string msg);
    checks_done++;
    if (seen !== exp) begin
      error_cnt++;
      $display("MISMATCH t=%0t %s seen %h exp %h", $time, msg, seen, exp);
    end
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] e,
                    input string msg);
    fw.xfer(1'b0, a, 4'hf, 32'h0000_0000, rdat);
    check(rdat, e, msg);
  endtask

  // Toggle one source for a single cycle; cmp0 low-high is its edge
  task automatic fire(input logic [2:0] i);
    @(posedge clk_i);
    src[i] <= ~src[i];
    @(posedge clk_i);
    src[i] <= ~src[i];
    #1;
  endtask

  task automatic end_of_test();
    $display("checks %0d errors %0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  ////////////////////////////////////////////////////////////
  // Watchdog sized well past the pin waits of the run
  initial begin
    repeat (40000) @(posedge clk_i);
    error_cnt++;
    end_of_test();
  end

  initial begin
    rows = '{'{8'h41, 3'd0, 1'b1, 8'h01}, '{8'h42, 3'd1, 1'b1, 8'h02},
      '{8'h44, 3'd2, 1'b1, 8'h04}, '{8'h48, 3'd3, 1'b1, 8'h08},
      '{8'h50, 3'd4, 1'b1, 8'h10}, '{8'h40, 3'd0, 1'b0, 8'h20},
      '{8'h40, 3'd5, 1'b1, 8'h20}, '{8'h82, 3'd1, 1'b1, 8'h02},
      '{8'h84, 3'd2, 1'b1, 8'h04}, '{8'h88, 3'd3, 1'b1, 8'h08},
      '{8'h90, 3'd4, 1'b1, 8'h10}, '{8'h81, 3'd0, 1'b0, 8'h20},
      '{8'h80, 3'd5, 1'b1, 8'h20}, '{8'hd0, 3'd4, 1'b1, 8'h10}};
    repeat (7) @(posedge clk_i);
    #1;
    check({sys_clk_en, osc_en, halt, core_en, ram_vdd, wake_n, mon_en},
          7'b1101011, "reset outputs");
    @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    #1;
    check(xram_we, 1'b1, "xram clear after reset");
    // Table of entries, sources and expected wake flags
    foreach (rows[k]) begin
      fw.enter_lp(rows[k].cfg);
      #1;
      check(sys_clk_en, 1'b0, "clock gated");
      check(halt, 1'b1, "halted");
      if (!rows[k].cfg[7]) check(osc_en, 1'b0, "osc off");
      check(core_en, !rows[k].cfg[7], "regulator");
      check({ram_vdd, retain, hold}, {3{rows[k].cfg[7]}}, "keep");
      rd(lpm_pkg::OFS_STAT, rows[k].cfg[7] ? 2 : 1, "entered");
      fire(rows[k].src);
      check(sys_clk_en, rows[k].wake, "wake");
      if (!rows[k].wake) fire(3'd5);
      if (rows[k].cfg[7]) begin
        check({wake_n, xram_we}, 2'b01, "sleep exit");
        repeat (16) @(posedge clk_i);
        #1;
        check(wake_n, 1'b1, "wake request end");
      end
      rd(lpm_pkg::OFS_STAT, 0, "awake");
      rd(lpm_pkg::OFS_CFG, rows[k].flags, "flags");
      if (rows[k].flags[5]) fw.hold_off();
    end
    // Flags stay zero just after a suspend exit
    fw.enter_lp(8'h50);
    fire(3'd4);
    rd(lpm_pkg::OFS_CFG, 0, "early flags");
    rd(lpm_pkg::OFS_CFG, 32'h0000_0010, "late flags");
    // A pin held low past the window resets the part
    @(posedge clk_i);
    src[5] <= 1'b0;
    n = 0;
    while (pin_rst !== 1'b1 && n < 4000) begin
      @(posedge clk_i);
      n++;
    end
    check(n > 2990 && n < 3010, 1'b1, "pin reset delay");
    src[5] <= 1'b1;
    // Refused writes leave the monitor alone
    fw.xfer(1'b1, 8'h0c, 4'h1, 32'h0000_00ff, rdat);
    rd(8'h0c, 0, "unmapped");
    fw.xfer(1'b1, lpm_pkg::OFS_MODE, 4'he, 32'h0000_0020, rdat);
    rd(lpm_pkg::OFS_MODE, 0, "lane off");
    fw.xfer(1'b1, lpm_pkg::OFS_MODE, 4'h1, 32'h0000_0020, rdat);
    #1;
    check(mon_en, 1'b0, "monitor off");
    rd(lpm_pkg::OFS_MODE, 32'h0000_0020, "monitor bit");
    @(posedge clk_i);
    reset_src <= 1'b1;
    @(posedge clk_i);
    reset_src <= 1'b0;
    #1;
    check({full_por, mon_en}, 2'b11, "full por");
    // Reset in mid-sleep brings every control back awake
    fw.enter_lp(8'h88);
    @(posedge clk_i);
    rst_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    #1;
    check({sys_clk_en, core_en, ram_vdd, hold}, 4'b1100, "mid reset");
    @(posedge clk_i);
    #1;
    check(xram_we, 1'b1, "xram clear after mid reset");
    rd(lpm_pkg::OFS_STAT, 0, "state after mid reset");
    end_of_test();
  end
endmodule

// >>> verilog/lpm_pkg.sv
package lpm_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Register byte offsets on the Wishbone bus
  localparam logic [7:0] OFS_CFG = 8'h00;
  localparam logic [7:0] OFS_MODE = 8'h04;
  localparam logic [7:0] OFS_STAT = 8'h08;

  ////////////////////////////////////////////////////////////////////////////
  // Field positions in power_mode_config
  localparam int CFG_SLEEP = 7;
  localparam int CFG_SUSPEND = 6;
  localparam int CFG_RSTWAKE = 5;
  localparam int WK_N = 5;
  localparam int WK_CSENSE = 0;
  localparam int WK_RTC_FAIL = 1;
  localparam int WK_RTC_ALARM = 2;
  localparam int WK_PORT_MATCH = 3;
  localparam int WK_CMP0 = 4;
  // Field position in power_unit_mode_reg
  localparam int MODE_MON_DIS = 5;

  // Sources that can wake sleep (core supply off) and suspend
  localparam logic [WK_N-1:0] SLEEP_WK_MASK = 5'h1e;
  localparam logic [WK_N-1:0] SUSP_WK_MASK = 5'h1f;

  ////////////////////////////////////////////////////////////////////////////
  // Reset values
  localparam logic [WK_N-1:0] WK_RST = 5'h00;
  localparam logic MON_DIS_RST = 1'b0;

  ////////////////////////////////////////////////////////////////////////////
  // Timing
  localparam int CLK_MHZ = 200;
  localparam int RST_WAIT_US = 15;
  localparam logic [11:0] RST_WAIT_CYC = 12'(RST_WAIT_US * CLK_MHZ);
  localparam logic [1:0] FLAG_DLY_CYC = 2'h2;
  localparam logic [4:0] WAKE_OUT_CYC = 5'h10;

  typedef enum logic [1:0] {
    ST_AWAKE,
    ST_SUSPEND,
    ST_SLEEP
  } lpm_state_t;

endpackage

// >>> verilog/lpm_top.sv
// Implementation choices: the Wishbone interface to the registers and the register offsets.
`timescale 1ns/1ps

//////////////////////////////////////////////////////////////////////////////
// Function
// - Suspend select gates system clock and stops all internal oscillators.
// - During suspend CPU and all digital logic stay halted until a wake.
// - Suspend wakes on cap-sense, RTC fail, RTC alarm, port match, comparator.
// - Wake flags read zero for two clocks after suspend exit.
// - Short reset-pin glitch ends suspend; firmware waits 15 us to re-enter.
// - Config register shows reset-pin wake; other wakes allow instant re-entry.
// - Sleep select turns core regulator off, RAM on supply pin.
// - Comparators, RTC and port match work in sleep; firmware selects low-power oscillator.
// - Digital output pins hold their levels while asleep.
// - Digital input pins remain usable for port match during sleep.
// - Leaving sleep drives the wake request output low.
// - Sleep retains RAM, registers, program counter and volatile state.
// - Reset or sleep exit may write 0x00 to external address zero.
// - Sleep wakes on RTC fail, RTC alarm, port match, comparator edge.
// - Monitor disable bit; any reset source then forces full POR.
// - Any reset-pin falling edge ends sleep; firmware waits 15 us.
// - Each wake source is enabled by writing one to its bit.
// - Reset pin always wakes; reset acts if awake beyond 15 us.
module lpm_top (
  input wire logic clk_i,
  input wire logic rst_i,
  // Wishbone classic slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // Wake and reset sources
  input wire logic csense_done_i,
  input wire logic rtc_osc_fail_i,
  input wire logic rtc_alarm_i,
  input wire logic port_match_i,
  input wire logic cmp0_i,
  input wire logic rst_pin_n_i,
  input wire logic reset_src_i,
  // Power controls
  output logic sys_clk_en_o,
  output logic osc_en_o,
  output logic cpu_halt_o,
  output logic core_reg_en_o,
  output logic ram_on_vdd_o,
  output logic retain_o,
  output logic pin_hold_o,
  output logic wake_req_n_o,
  output logic pin_reset_o,
  output logic full_por_o,
  output logic por_mon_en_o,
  output logic xram0_zero_we_o
);

  //////////////////////////////////////////////////////////////////////////
  // State
  lpm_pkg::lpm_state_t state_q, state_d;
  logic [lpm_pkg::WK_N-1:0] en_q, en_d;
  logic [lpm_pkg::WK_N-1:0] flags_q, flags_d;
  logic rstwake_q, rstwake_d;
  logic mon_dis_q, mon_dis_d;
  logic [1:0] flag_dly_q, flag_dly_d;
  logic [11:0] rst_win_q, rst_win_d;
  logic [4:0] wake_cnt_q, wake_cnt_d;
  logic rst_pin_prev_q, cmp0_prev_q;
  logic boot_q;
  logic ack_q, ack_d;
  logic [31:0] dat_q, dat_d;
  logic sys_clk_en_q, sys_clk_en_d;
  logic osc_en_q, osc_en_d;
  logic halt_q, halt_d;
  logic core_reg_q, core_reg_d;
  logic ram_vdd_q, ram_vdd_d;
  logic pin_reset_q, pin_reset_d;
  logic full_por_q, full_por_d;
  logic xram_we_q, xram_we_d;
  logic wake_n_q, wake_n_d;
  logic mon_en_q, mon_en_d;

  logic [lpm_pkg::WK_N-1:0] src;
  logic [lpm_pkg::WK_N-1:0] hit;
  logic rst_fall;
  logic bus_req;
  logic wr_cfg;

  // Edge detects; pins are synchronous to clk_i
  assign rst_fall = rst_pin_prev_q & ~rst_pin_n_i;
  assign src = {cmp0_i & ~cmp0_prev_q, port_match_i, rtc_alarm_i,
                rtc_osc_fail_i, csense_done_i};
  assign bus_req = wb_cyc_i & wb_stb_i & ~ack_q;
  assign wr_cfg = bus_req & wb_we_i & wb_sel_i[0] &
                  (wb_adr_i == lpm_pkg::OFS_CFG);

  // Enabled sources that can fire in the present mode
  always_comb begin
    hit = '0;
    unique case (state_q)
      lpm_pkg::ST_SUSPEND: hit = src & en_q & lpm_pkg::SUSP_WK_MASK;
      lpm_pkg::ST_SLEEP: hit = src & en_q & lpm_pkg::SLEEP_WK_MASK;
      lpm_pkg::ST_AWAKE: hit = '0;
    endcase
  end

  //////////////////////////////////////////////////////////////////////////
  // Next-state logic for mode, flags, bus and outputs
  always_comb begin
    state_d = state_q;
    en_d = en_q;
    flags_d = flags_q;
    rstwake_d = rstwake_q;
    mon_dis_d = mon_dis_q;
    flag_dly_d = (flag_dly_q != 2'h0) ? flag_dly_q - 2'h1 : 2'h0;
    rst_win_d = (rst_win_q != 12'h000) ? rst_win_q - 12'h001 : 12'h000;
    wake_cnt_d = (wake_cnt_q != 5'h00) ? wake_cnt_q - 5'h01 : 5'h00;
    pin_reset_d = 1'b0;
    full_por_d = 1'b0;
    xram_we_d = boot_q;
    ack_d = bus_req;
    dat_d = '0;

    // Bus reads; flags hidden while the wake record settles
    if (bus_req && !wb_we_i) begin
      unique case (wb_adr_i)
        lpm_pkg::OFS_CFG: begin
          if (flag_dly_q == 2'h0) begin
            dat_d[lpm_pkg::CFG_RSTWAKE] = rstwake_q;
            dat_d[lpm_pkg::WK_N-1:0] = flags_q;
          end
        end
        lpm_pkg::OFS_MODE: dat_d[lpm_pkg::MODE_MON_DIS] = mon_dis_q;
        lpm_pkg::OFS_STAT: dat_d[1:0] = state_q;
        default: dat_d = '0;
      endcase
    end

    // Mode entry; enables taken from the same write
    if (wr_cfg && state_q == lpm_pkg::ST_AWAKE) begin
      en_d = wb_dat_i[lpm_pkg::WK_N-1:0];
      if (wb_dat_i[lpm_pkg::CFG_SLEEP] || wb_dat_i[lpm_pkg::CFG_SUSPEND]) begin
        flags_d = '0;
        rstwake_d = 1'b0;
        // Leaving early abandons a pending pin reset
        rst_win_d = 12'h000;
        state_d = wb_dat_i[lpm_pkg::CFG_SLEEP] ? lpm_pkg::ST_SLEEP
                                               : lpm_pkg::ST_SUSPEND;
      end
    end
    if (bus_req && wb_we_i && wb_sel_i[0] &&
        wb_adr_i == lpm_pkg::OFS_MODE) begin
      mon_dis_d = wb_dat_i[lpm_pkg::MODE_MON_DIS];
    end

    // Wake; set after clear so an event is never lost
    // any reset-pin falling edge ends low power
    if (state_q != lpm_pkg::ST_AWAKE && (rst_fall || hit != '0)) begin
      state_d = lpm_pkg::ST_AWAKE;
      flags_d = flags_q | hit;
      rstwake_d = rstwake_q | rst_fall;
      en_d = '0;
      if (state_q == lpm_pkg::ST_SUSPEND) begin
        flag_dly_d = lpm_pkg::FLAG_DLY_CYC;
      end
      if (state_q == lpm_pkg::ST_SLEEP) begin
        wake_cnt_d = lpm_pkg::WAKE_OUT_CYC;
        xram_we_d = 1'b1;
      end
    end

    if (rst_fall) begin
      rst_win_d = lpm_pkg::RST_WAIT_CYC;
    end else if (rst_win_q == 12'h001 && !rst_pin_n_i &&
                 state_q == lpm_pkg::ST_AWAKE) begin
      pin_reset_d = 1'b1;
    end

    if (mon_dis_q && (reset_src_i || pin_reset_d)) begin
      full_por_d = 1'b1;
      mon_dis_d = 1'b0;
    end

    // clock gate and oscillators off in either low-power mode
    sys_clk_en_d = (state_d == lpm_pkg::ST_AWAKE);
    osc_en_d = (state_d == lpm_pkg::ST_AWAKE);
    halt_d = (state_d != lpm_pkg::ST_AWAKE);
    // core regulator off, RAM to supply pin
    core_reg_d = (state_d != lpm_pkg::ST_SLEEP);
    ram_vdd_d = (state_d == lpm_pkg::ST_SLEEP);
    // Registered copies so these pins leave a flip-flop
    wake_n_d = (wake_cnt_d == 5'h00);
    mon_en_d = ~mon_dis_d;
  end

  // Registers; outputs all leave from here
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_q <= lpm_pkg::ST_AWAKE;
      en_q <= lpm_pkg::WK_RST;
      flags_q <= lpm_pkg::WK_RST;
      rstwake_q <= 1'b0;
      mon_dis_q <= lpm_pkg::MON_DIS_RST;
      flag_dly_q <= 2'h0;
      rst_win_q <= 12'h000;
      wake_cnt_q <= 5'h00;
      rst_pin_prev_q <= 1'b1;
      cmp0_prev_q <= 1'b0;
      boot_q <= 1'b1;
      ack_q <= 1'b0;
      dat_q <= '0;
      sys_clk_en_q <= 1'b1;
      osc_en_q <= 1'b1;
      halt_q <= 1'b0;
      core_reg_q <= 1'b1;
      ram_vdd_q <= 1'b0;
      pin_reset_q <= 1'b0;
      full_por_q <= 1'b0;
      xram_we_q <= 1'b0;
      wake_n_q <= 1'b1;
      mon_en_q <= ~lpm_pkg::MON_DIS_RST;
    end else begin
      state_q <= state_d;
      en_q <= en_d;
      flags_q <= flags_d;
      rstwake_q <= rstwake_d;
      mon_dis_q <= mon_dis_d;
      flag_dly_q <= flag_dly_d;
      rst_win_q <= rst_win_d;
      wake_cnt_q <= wake_cnt_d;
      rst_pin_prev_q <= rst_pin_n_i;
      cmp0_prev_q <= cmp0_i;
      boot_q <= 1'b0;
      ack_q <= ack_d;
      dat_q <= dat_d;
      sys_clk_en_q <= sys_clk_en_d;
      osc_en_q <= osc_en_d;
      halt_q <= halt_d;
      core_reg_q <= core_reg_d;
      ram_vdd_q <= ram_vdd_d;
      pin_reset_q <= pin_reset_d;
      full_por_q <= full_por_d;
      xram_we_q <= xram_we_d;
      wake_n_q <= wake_n_d;
      mon_en_q <= mon_en_d;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Output map; retention and pin hold follow the regulator state
  assign wb_ack_o = ack_q;
  assign wb_dat_o = dat_q;
  assign sys_clk_en_o = sys_clk_en_q;
  assign osc_en_o = osc_en_q;
  assign cpu_halt_o = halt_q;
  assign core_reg_en_o = core_reg_q;
  assign ram_on_vdd_o = ram_vdd_q;
  assign retain_o = ram_vdd_q;
  assign pin_hold_o = ram_vdd_q;
  assign wake_req_n_o = wake_n_q;
  assign pin_reset_o = pin_reset_q;
  assign full_por_o = full_por_q;
  assign por_mon_en_o = mon_en_q;
  assign xram0_zero_we_o = xram_we_q;

  //////////////////////////////////////////////////////////////////////////
  // Assertions
  sequence s_susp_exit;
    state_q == lpm_pkg::ST_SUSPEND && state_d == lpm_pkg::ST_AWAKE;
  endsequence

  sequence s_sleep_exit;
    state_q == lpm_pkg::ST_SLEEP && state_d == lpm_pkg::ST_AWAKE;
  endsequence

  property p_susp_gate;
    @(posedge clk_i) disable iff (rst_i)
    ##1 (state_q == lpm_pkg::ST_SUSPEND) |-> !sys_clk_en_o && !osc_en_o;
  endproperty
  a_susp_gate: assert property (p_susp_gate)
    else $error("clock not gated in suspend");

  property p_halt;
    @(posedge clk_i) disable iff (rst_i)
    ##1 (state_q != lpm_pkg::ST_AWAKE) |-> cpu_halt_o;
  endproperty
  a_halt: assert property (p_halt)
    else $error("cpu not halted in low power");

  property p_flag_hide;
    @(posedge clk_i) disable iff (rst_i)
    s_susp_exit |=> flag_dly_q == 2'h2 ##1 flag_dly_q == 2'h1
                    ##1 flag_dly_q == 2'h0;
  endproperty
  a_flag_hide: assert property (p_flag_hide)
    else $error("flag hide window not two clocks");

  property p_sleep_power;
    @(posedge clk_i) disable iff (rst_i)
    ##1 (state_q == lpm_pkg::ST_SLEEP) |-> !core_reg_en_o && ram_on_vdd_o;
  endproperty
  a_sleep_power: assert property (p_sleep_power)
    else $error("regulator on during sleep");

  property p_en_clear;
    @(posedge clk_i) disable iff (rst_i)
    (s_susp_exit or s_sleep_exit) |=> en_q == '0;
  endproperty
  a_en_clear: assert property (p_en_clear)
    else $error("wake enables not cleared");

  property p_wake_out;
    @(posedge clk_i) disable iff (rst_i)
    s_sleep_exit |=> !wake_req_n_o [*8];
  endproperty
  a_wake_out: assert property (p_wake_out)
    else $error("wake request not driven low");

  property p_full_por;
    @(posedge clk_i) disable iff (rst_i)
    mon_dis_q && reset_src_i |=> full_por_o && por_mon_en_o;
  endproperty
  a_full_por: assert property (p_full_por)
    else $error("no full POR with monitor off");

  property p_pin_wake;
    @(posedge clk_i) disable iff (rst_i)
    (state_q != lpm_pkg::ST_AWAKE) && rst_fall |=>
      state_q == lpm_pkg::ST_AWAKE && rstwake_q;
  endproperty
  a_pin_wake: assert property (p_pin_wake)
    else $error("reset pin edge did not wake");

  property p_sleep_sources;
    @(posedge clk_i) disable iff (rst_i)
    state_q == lpm_pkg::ST_SLEEP && !rst_fall &&
      (src & en_q & lpm_pkg::SLEEP_WK_MASK) == '0
      |=> state_q == lpm_pkg::ST_SLEEP;
  endproperty
  a_sleep_sources: assert property (p_sleep_sources)
    else $error("sleep left without a valid source");

  property p_pin_reset;
    @(posedge clk_i) disable iff (rst_i)
    $rose(rst_win_q == lpm_pkg::RST_WAIT_CYC) && !rst_pin_n_i
      ##1 (!rst_pin_n_i && state_q == lpm_pkg::ST_AWAKE) [*8]
      |-> !pin_reset_o;
  endproperty
  a_pin_reset: assert property (p_pin_reset)
    else $error("pin reset before window end");

  property p_ack;
    @(posedge clk_i) disable iff (rst_i)
    bus_req |=> wb_ack_o ##1 !wb_ack_o;
  endproperty
  a_ack: assert property (p_ack)
    else $error("bus ack not a single cycle");

endmodule
